// ==== hdl/pts_map.svh ====
// register offsets, entry field layout, limits and timing counts
// How it works
// - each entry holds a deceleration from 0 to 2147483647 in fine units
// - stopping time follows commanded speed divided by the entry deceleration
// - a zero deceleration falls back to the global deceleration time constant
// - auxiliary codes 0 and 2 ignore the entry dwell time
// - continuing codes with zero dwell run the next entry without stopping unless it reverses direction
// - nonzero dwell finishes the entry, waits the dwell, then starts the next
// - only codes 0-3 and 8-11 are accepted; codes 0 and 2 run one entry only
// - some codes step into the next-numbered entry without stopping
// - some codes loop back to the entry selected at start
// - some codes loop back to entry number 1
// - entry 255 with code 1 or 3 raises a table error
// - reversing waits for the command output to reach zero speed
// - each entry carries a completion code shown once the entry finishes
// - the completion code is readable by the host through a readback register
// - in degree units position data is held to -360000..360000
// - speed clamps to the maximum, or the permissible speed when selected
// - in linear mode the speed fields are taken as mm/s
// - actual entry and completion code hold old values until completion
`ifndef PTS_MAP_SVH
`define PTS_MAP_SVH
`define PTS_CLK_NS 10
`define PTS_TICK_NS 1000000
`define PTS_TICK_CYC (`PTS_TICK_NS / `PTS_CLK_NS)
`define PTS_A_CTRL 8'h00
`define PTS_A_TARGET 8'h04
`define PTS_A_STATUS 8'h08
`define PTS_A_ACT 8'h0C
`define PTS_A_MCODE 8'h10
`define PTS_A_POS 8'h14
`define PTS_A_VEL 8'h18
`define PTS_A_CFG 8'h1C
`define PTS_A_GTC 8'h20
`define PTS_A_MAXSPD 8'h24
`define PTS_A_PERMSPD 8'h28
`define PTS_A_TIDX 8'h2C
`define PTS_A_TPOS 8'h30
`define PTS_A_TSPD 8'h34
`define PTS_A_TDEC 8'h38
`define PTS_A_TDWELL 8'h3C
`define PTS_A_TAUX 8'h40
`define PTS_A_COMMIT 8'h44
`define PTS_CTRL_SETPT 4
`define PTS_CFG_DEG 0
`define PTS_CFG_RATE 1
`define PTS_CFG_SPDLIM 2
`define PTS_CFG_LINEAR 3
`define PTS_E_POS 0
`define PTS_E_SPD 32
`define PTS_E_DEC 64
`define PTS_E_DWELL 96
`define PTS_E_AUX 112
`define PTS_E_MCODE 116
`define PTS_E_W 124
`define PTS_DEG_MAX 32'sd360000
`define PTS_DEC_MAX 32'h7FFFFFFF
`define PTS_DWELL_MAX 16'd20000
`define PTS_LAST_ENTRY 8'hFF
`define PTS_FIRST_ENTRY 8'h01
`define PTS_GTC_RST 32'h00000064
`define PTS_MAXSPD_RST 32'h00000BB8
`define PTS_PERMSPD_RST 32'h00000FA0
`define PTS_RESP_OK 2'b00
`define PTS_RESP_ERR 2'b10
`endif

// ==== hdl/pts_pkg.sv ====
// types shared by the point-table sequencer
package pts_pkg;
  typedef logic [7:0] pts_addr_t;
  typedef logic [31:0] pts_word_t;
  typedef enum logic [2:0] {
    PTS_IDLE = 3'b000,
    PTS_LOAD = 3'b001,
    PTS_STEP = 3'b011,
    PTS_NCALC = 3'b010,
    PTS_RUN = 3'b110,
    PTS_DWELL = 3'b111,
    PTS_REVZ = 3'b100
  } pts_state_t;
endpackage

// ==== hdl/pts_mem.sv ====
// point table storage, one packed entry per table number
`timescale 1ns/100ps
`include "pts_map.svh"
module pts_mem (
  input wire logic clk, // system clock
  input wire logic we, // write enable
  input wire logic [7:0] waddr, // entry written
  input wire logic [`PTS_E_W-1:0] wdata, // packed entry
  input wire logic [7:0] raddr, // entry read
  output logic [`PTS_E_W-1:0] rdata // packed entry, combinational
);
  logic [`PTS_E_W-1:0] mem [0:255];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata = mem[raddr];
endmodule

// ==== hdl/pts_div.sv ====
// serial unsigned divider, 32 cycles, zero divisor gives all ones
`timescale 1ns/100ps
module pts_div (
  input wire logic clk, // system clock
  input wire logic rst, // async reset, active high
  input wire logic start, // one-cycle start pulse
  input wire logic [31:0] num, // dividend
  input wire logic [31:0] den, // divisor
  output logic done, // one-cycle pulse, quo valid
  output logic [31:0] quo // quotient
);
  logic [31:0] rem_r;
  logic [31:0] q_r;
  logic [31:0] d_r;
  logic [5:0] cnt_r;
  logic [32:0] trial;

  assign trial = {rem_r, q_r[31]} - {1'b0, d_r};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rem_r <= 32'h00000000;
      q_r <= 32'h00000000;
      d_r <= 32'h00000000;
      cnt_r <= 6'h00;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        rem_r <= 32'h00000000;
        q_r <= num;
        d_r <= den;
        cnt_r <= 6'h20;
      end else if (cnt_r != 6'h00) begin
        if (!trial[32]) begin
          rem_r <= trial[31:0];
          q_r <= {q_r[30:0], 1'b1};
        end else begin
          rem_r <= {rem_r[30:0], q_r[31]};
          q_r <= {q_r[30:0], 1'b0};
        end
        cnt_r <= cnt_r - 6'h01;
        done <= (cnt_r == 6'h01);
      end
    end
  end

  assign quo = q_r;
endmodule

// ==== hdl/pts_seq.sv ====
// point-table sequencer top: AXI4-Lite registers, table walk, profile
//
// The address map and the AXI4-Lite register port were decided locally.
`timescale 1ns/100ps
`include "pts_map.svh"
module pts_seq #(
  parameter int TICK_CYC = `PTS_TICK_CYC
) (
  input wire logic CLK, // system clock, 100 MHz
  input wire logic RST, // async reset, active high
  input wire pts_pkg::pts_addr_t S_AXI_AWADDR, // write address
  input wire logic S_AXI_AWVALID, // write address valid
  output logic S_AXI_AWREADY, // write address ready
  input wire pts_pkg::pts_word_t S_AXI_WDATA, // write data
  input wire logic [3:0] S_AXI_WSTRB, // write byte strobes
  input wire logic S_AXI_WVALID, // write data valid
  output logic S_AXI_WREADY, // write data ready
  output logic [1:0] S_AXI_BRESP, // write response
  output logic S_AXI_BVALID, // write response valid
  input wire logic S_AXI_BREADY, // write response ready
  input wire pts_pkg::pts_addr_t S_AXI_ARADDR, // read address
  input wire logic S_AXI_ARVALID, // read address valid
  output logic S_AXI_ARREADY, // read address ready
  output pts_pkg::pts_word_t S_AXI_RDATA, // read data
  output logic [1:0] S_AXI_RRESP, // read response
  output logic S_AXI_RVALID, // read data valid
  input wire logic S_AXI_RREADY, // read data ready
  output pts_pkg::pts_word_t CMD_POS, // commanded position
  output pts_pkg::pts_word_t CMD_VEL, // commanded speed magnitude
  output logic CMD_DIR, // 1 = negative direction
  output logic [7:0] MCODE, // completion code of last finished entry
  output logic TBL_ERR // table error, cleared by next start
);
  import pts_pkg::*;

  // bus slave state
  logic aw_hold_r, w_hold_r;
  pts_addr_t awaddr_r;
  pts_word_t wdata_r;
  logic [3:0] wstrb_r;
  logic wr_go, wr_hit, rd_hit;
  pts_word_t rd_mux;
  // software registers
  logic [31:0] ctrl_r, target_r, cfg_r, gtc_r, max_r, perm_r;
  logic [31:0] tidx_r, tpos_r, tspd_r, tdec_r, tdwell_r, taux_r;
  logic start_req, commit;
  // sequencer state
  pts_state_t state_r;
  logic ph_r, ndir_r;
  logic [7:0] entry_r, start_ent_r, act_r;
  logic [TICK_CYC > 1 ? $clog2(TICK_CYC) - 1 : 0:0] tick_cnt_r;
  logic tick;
  logic [`PTS_E_W-1:0] ent;
  logic [31:0] e_pos, e_spd, e_dec, spd_lim;
  logic [15:0] e_dwell, dwell_r, dcnt_r;
  logic [3:0] e_aux, aux_r;
  logic [7:0] e_mcode, mcode_r;
  logic signed [31:0] pos_c, tgt_r, tgt_c;
  logic [31:0] spd_r, dec_r, step_r, stop_r, dist_r;
  logic [31:0] vel_run, vel_rev, adv;
  logic [63:0] prod;
  logic aux_ok, aux_cont, aux_rel, halt, bad_ent, run_end, dir_c;
  logic div_start, div_done;
  logic [31:0] div_num, div_den, div_q;

  function automatic logic [31:0] merge(input logic [31:0] o,
      input logic [31:0] n, input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = n[8*i +: 8];
      end
    end
    return r;
  endfunction

  // ---------------- AXI4-Lite write path
  assign wr_go = aw_hold_r && w_hold_r && !S_AXI_BVALID;
  assign wr_hit = (awaddr_r[1:0] == 2'b00) && (awaddr_r <= `PTS_A_COMMIT);

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `PTS_RESP_OK;
    end else begin
      S_AXI_AWREADY <= !aw_hold_r && !(S_AXI_AWVALID && S_AXI_AWREADY);
      S_AXI_WREADY <= !w_hold_r && !(S_AXI_WVALID && S_AXI_WREADY);
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_hold_r <= 1'b1;
        awaddr_r <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_hold_r <= 1'b1;
        wdata_r <= S_AXI_WDATA;
        wstrb_r <= S_AXI_WSTRB;
      end
      if (wr_go) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= wr_hit ? `PTS_RESP_OK : `PTS_RESP_ERR;
      end else if (S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // set-point rising edge starts a run only when stopped
  assign start_req = wr_go && awaddr_r == `PTS_A_CTRL && wstrb_r[0]
    && wdata_r[`PTS_CTRL_SETPT] && !ctrl_r[`PTS_CTRL_SETPT];
  assign commit = wr_go && awaddr_r == `PTS_A_COMMIT;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ctrl_r <= 32'h00000000;
      target_r <= 32'h00000001;
      cfg_r <= 32'h00000000;
      gtc_r <= `PTS_GTC_RST;
      max_r <= `PTS_MAXSPD_RST;
      perm_r <= `PTS_PERMSPD_RST;
      tidx_r <= 32'h00000000;
      tpos_r <= 32'h00000000;
      tspd_r <= 32'h00000000;
      tdec_r <= 32'h00000000;
      tdwell_r <= 32'h00000000;
      taux_r <= 32'h00000000;
    end else if (wr_go) begin
      unique case (awaddr_r)
        `PTS_A_CTRL: ctrl_r <= merge(ctrl_r, wdata_r, wstrb_r) & 32'h10;
        `PTS_A_TARGET: target_r <= merge(target_r, wdata_r, wstrb_r) & 32'hFF;
        `PTS_A_CFG: cfg_r <= merge(cfg_r, wdata_r, wstrb_r) & 32'hF;
        `PTS_A_GTC: gtc_r <= merge(gtc_r, wdata_r, wstrb_r);
        `PTS_A_MAXSPD: max_r <= merge(max_r, wdata_r, wstrb_r);
        `PTS_A_PERMSPD: perm_r <= merge(perm_r, wdata_r, wstrb_r);
        `PTS_A_TIDX: tidx_r <= merge(tidx_r, wdata_r, wstrb_r) & 32'hFF;
        `PTS_A_TPOS: tpos_r <= merge(tpos_r, wdata_r, wstrb_r);
        `PTS_A_TSPD: tspd_r <= merge(tspd_r, wdata_r, wstrb_r);
        `PTS_A_TDEC: tdec_r <= merge(tdec_r, wdata_r, wstrb_r);
        `PTS_A_TDWELL: tdwell_r <= merge(tdwell_r, wdata_r, wstrb_r);
        `PTS_A_TAUX: taux_r <= merge(taux_r, wdata_r, wstrb_r) & 32'hFF0F;
        default: ;
      endcase
    end
  end

  // ---------------- AXI4-Lite read path
  assign rd_hit = (S_AXI_ARADDR[1:0] == 2'b00)
    && (S_AXI_ARADDR <= `PTS_A_COMMIT);

  always_comb begin
    unique case (S_AXI_ARADDR)
      `PTS_A_CTRL: rd_mux = ctrl_r;
      `PTS_A_TARGET: rd_mux = target_r;
      `PTS_A_STATUS: rd_mux = {25'h0, state_r, 1'b0,
        state_r != PTS_IDLE, TBL_ERR, CMD_VEL != 32'h0};
      `PTS_A_ACT: rd_mux = {24'h0, act_r};
      `PTS_A_MCODE: rd_mux = {24'h0, MCODE};
      `PTS_A_POS: rd_mux = CMD_POS;
      `PTS_A_VEL: rd_mux = CMD_VEL;
      `PTS_A_CFG: rd_mux = cfg_r;
      `PTS_A_GTC: rd_mux = gtc_r;
      `PTS_A_MAXSPD: rd_mux = max_r;
      `PTS_A_PERMSPD: rd_mux = perm_r;
      `PTS_A_TIDX: rd_mux = tidx_r;
      `PTS_A_TPOS: rd_mux = tpos_r;
      `PTS_A_TSPD: rd_mux = tspd_r;
      `PTS_A_TDEC: rd_mux = tdec_r;
      `PTS_A_TDWELL: rd_mux = tdwell_r;
      `PTS_A_TAUX: rd_mux = taux_r;
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= `PTS_RESP_OK;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= rd_mux;
      S_AXI_RRESP <= rd_hit ? `PTS_RESP_OK : `PTS_RESP_ERR;
    end else if (S_AXI_RVALID) begin
      S_AXI_RVALID <= !S_AXI_RREADY;
      S_AXI_ARREADY <= S_AXI_RREADY;
    end else begin
      S_AXI_ARREADY <= 1'b1;
    end
  end

  // ---------------- table storage and divider
  pts_mem u_mem (
    .clk(CLK),
    .we(commit),
    .waddr(tidx_r[7:0]),
    .wdata({taux_r[15:8], taux_r[3:0], tdwell_r[15:0], tdec_r, tspd_r,
      tpos_r}),
    .raddr(entry_r),
    .rdata(ent)
  );

  assign div_num = (state_r == PTS_STEP) ? spd_lim : spd_r;
  assign div_den = (state_r == PTS_STEP) ? gtc_r : step_r;
  assign div_start = !ph_r && ((state_r == PTS_STEP && dec_r == 32'h0)
    || state_r == PTS_NCALC);

  pts_div u_div (
    .clk(CLK),
    .rst(RST),
    .start(div_start),
    .num(div_num),
    .den(div_den),
    .done(div_done),
    .quo(div_q)
  );

  // ---------------- millisecond tick
  assign tick = (tick_cnt_r == ($bits(tick_cnt_r))'(TICK_CYC - 1));

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick ? '0 : tick_cnt_r + 1'b1;
    end
  end

  // ---------------- entry decode
  assign e_pos = ent[`PTS_E_POS +: 32];
  assign e_spd = ent[`PTS_E_SPD +: 32];
  assign e_dec = ent[`PTS_E_DEC +: 32] & `PTS_DEC_MAX;
  assign e_dwell = ent[`PTS_E_DWELL +: 16];
  assign e_aux = ent[`PTS_E_AUX +: 4];
  assign e_mcode = ent[`PTS_E_MCODE +: 8];
  // speed fields are in command units; linear mode means mm/s, same path
  assign spd_lim = cfg_r[`PTS_CFG_SPDLIM] ? perm_r : max_r;
  assign aux_ok = (e_aux <= 4'h3) || (e_aux >= 4'h8 && e_aux <= 4'hB);
  assign aux_rel = (e_aux <= 4'h3) ? e_aux[1] : e_aux[0];
  assign aux_cont = aux_r != 4'h0 && aux_r != 4'h2;
  assign halt = !aux_cont || dwell_r != 16'h0;
  assign bad_ent = !aux_ok || (entry_r == `PTS_LAST_ENTRY
    && (e_aux == 4'h1 || e_aux == 4'h3));

  always_comb begin
    pos_c = $signed(e_pos);
    if (cfg_r[`PTS_CFG_DEG] && pos_c > `PTS_DEG_MAX) begin
      pos_c = `PTS_DEG_MAX;
    end else if (cfg_r[`PTS_CFG_DEG] && pos_c < -`PTS_DEG_MAX) begin
      pos_c = -`PTS_DEG_MAX;
    end
  end

  assign tgt_c = aux_rel ? $signed(CMD_POS) + pos_c : pos_c;
  assign dir_c = tgt_c < $signed(CMD_POS);
  assign prod = spd_r * div_q;

  // ---------------- motion step per tick
  always_comb begin
    vel_run = spd_r;
    if (halt && dist_r <= stop_r) begin
      vel_run = (CMD_VEL > step_r + 32'h1) ? CMD_VEL - step_r : 32'h1;
    end else if (CMD_VEL > spd_r) begin
      vel_run = (CMD_VEL - spd_r > step_r) ? CMD_VEL - step_r : spd_r;
    end
    vel_rev = (CMD_VEL > step_r) ? CMD_VEL - step_r : 32'h0;
    adv = (vel_run < dist_r) ? vel_run : dist_r;
  end
  assign run_end = state_r == PTS_RUN && tick && adv == dist_r;

  // ---------------- sequencer state
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_r <= PTS_IDLE;
      ph_r <= 1'b0;
      entry_r <= 8'h00;
      start_ent_r <= 8'h00;
      dcnt_r <= 16'h0;
      TBL_ERR <= 1'b0;
    end else begin
      unique case (state_r)
        PTS_IDLE: if (start_req && CMD_VEL == 32'h0) begin
          entry_r <= target_r[7:0];
          start_ent_r <= target_r[7:0];
          TBL_ERR <= 1'b0;
          state_r <= PTS_LOAD;
        end
        PTS_LOAD: begin
          if (bad_ent) begin
            TBL_ERR <= 1'b1;
            state_r <= PTS_IDLE;
          end else if (CMD_VEL != 32'h0 && dir_c != CMD_DIR) begin
            state_r <= PTS_REVZ;
          end else begin
            state_r <= PTS_STEP;
          end
        end
        PTS_REVZ: if (tick && vel_rev == 32'h0) begin
          state_r <= PTS_STEP;
        end
        PTS_STEP: if (dec_r != 32'h0 || (ph_r && div_done)) begin
          ph_r <= 1'b0;
          state_r <= PTS_NCALC;
        end else begin
          ph_r <= 1'b1;
        end
        PTS_NCALC: if (ph_r && div_done) begin
          ph_r <= 1'b0;
          state_r <= PTS_RUN;
        end else begin
          ph_r <= 1'b1;
        end
        PTS_RUN: if (run_end) begin
          if (!aux_cont) begin
            state_r <= PTS_IDLE;
          end else if (dwell_r != 16'h0) begin
            dcnt_r <= dwell_r;
            state_r <= PTS_DWELL;
          end else begin
            state_r <= PTS_LOAD;
          end
          unique case (aux_r)
            4'h8, 4'h9: entry_r <= start_ent_r;
            4'hA, 4'hB: entry_r <= `PTS_FIRST_ENTRY;
            default: entry_r <= entry_r + 8'h01;
          endcase
        end
        PTS_DWELL: if (tick) begin
          dcnt_r <= dcnt_r - 16'h1;
          if (dcnt_r == 16'h1) begin
            state_r <= PTS_LOAD;
          end
        end
        default: state_r <= PTS_IDLE;
      endcase
    end
  end

  // ---------------- active entry fields, latched at entry start
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      spd_r <= 32'h0;
      dec_r <= 32'h0;
      dwell_r <= 16'h0;
      aux_r <= 4'h0;
      mcode_r <= 8'h00;
      tgt_r <= 32'sh0;
      ndir_r <= 1'b0;
      step_r <= 32'h1;
      stop_r <= 32'h0;
    end else begin
      if (state_r == PTS_LOAD && !bad_ent) begin
        spd_r <= (e_spd > spd_lim) ? spd_lim : e_spd;
        dec_r <= e_dec;
        dwell_r <= (e_dwell > `PTS_DWELL_MAX) ? `PTS_DWELL_MAX : e_dwell;
        aux_r <= e_aux;
        mcode_r <= e_mcode;
        tgt_r <= tgt_c;
        ndir_r <= dir_c;
      end
      if (state_r == PTS_STEP && !ph_r && dec_r != 32'h0) begin
        step_r <= dec_r;
      end else if (state_r == PTS_STEP && ph_r && div_done) begin
        step_r <= (div_q == 32'h0) ? 32'h1 : div_q;
      end
      if (state_r == PTS_NCALC && ph_r && div_done) begin
        stop_r <= (prod[63:33] != 31'h0) ? 32'hFFFFFFFF : prod[32:1];
      end
    end
  end

  // ---------------- command output and completion readback
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      CMD_POS <= 32'h0;
      CMD_VEL <= 32'h0;
      CMD_DIR <= 1'b0;
      dist_r <= 32'h0;
      act_r <= 8'h00;
      MCODE <= 8'h00;
    end else begin
      unique case (state_r)
        PTS_LOAD: if (bad_ent) begin
          CMD_VEL <= 32'h0;
        end
        PTS_REVZ: if (tick) begin
          CMD_VEL <= vel_rev;
          CMD_POS <= CMD_DIR ? CMD_POS - vel_rev : CMD_POS + vel_rev;
        end
        PTS_NCALC: if (ph_r && div_done) begin
          CMD_DIR <= ndir_r;
          dist_r <= ndir_r ? CMD_POS - tgt_r : tgt_r - CMD_POS;
        end
        PTS_RUN: if (tick) begin
          CMD_POS <= CMD_DIR ? CMD_POS - adv : CMD_POS + adv;
          dist_r <= dist_r - adv;
          CMD_VEL <= (run_end && halt) ? 32'h0 : vel_run;
          if (run_end) begin
            act_r <= entry_r;
            MCODE <= mcode_r;
          end
        end
        default: ;
      endcase
    end
  end
endmodule

// ==== verification/pts_seq_monitor.sv ====
// concurrent checks on the sequencer top ports
`timescale 1ns/100ps
module pts_seq_monitor (
  input wire logic CLK, // clock
  input wire logic RST, // reset
  input wire pts_pkg::pts_addr_t S_AXI_AWADDR, // aw
  input wire logic S_AXI_AWVALID, // aw
  input wire logic S_AXI_AWREADY, // aw
  input wire pts_pkg::pts_word_t S_AXI_WDATA, // w
  input wire logic [3:0] S_AXI_WSTRB, // w
  input wire logic S_AXI_WVALID, // w
  input wire logic S_AXI_WREADY, // w
  input wire logic [1:0] S_AXI_BRESP, // b
  input wire logic S_AXI_BVALID, // b
  input wire logic S_AXI_BREADY, // b
  input wire pts_pkg::pts_addr_t S_AXI_ARADDR, // ar
  input wire logic S_AXI_ARVALID, // ar
  input wire logic S_AXI_ARREADY, // ar
  input wire pts_pkg::pts_word_t S_AXI_RDATA, // r
  input wire logic [1:0] S_AXI_RRESP, // r
  input wire logic S_AXI_RVALID, // r
  input wire logic S_AXI_RREADY, // r
  input wire pts_pkg::pts_word_t CMD_POS, // position
  input wire pts_pkg::pts_word_t CMD_VEL, // speed
  input wire logic CMD_DIR, // direction
  input wire logic [7:0] MCODE, // completion code
  input wire logic TBL_ERR // table error
);
  import pts_pkg::*;
  default clocking mcb @(posedge CLK);
  endclocking
  default disable iff (RST);
  property p_r_lat;
    S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY;
  endproperty
  a_r_lat: assert property (p_r_lat)
    else $error("read answer missing");
  property p_r_hold;
    S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data not held");
  property p_b_lat;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
      |=> ##1 S_AXI_BVALID;
  endproperty
  a_b_lat: assert property (p_b_lat)
    else $error("write answer missing");
  property p_b_hold;
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response not held");
  property p_rev;
    $changed(CMD_DIR) |-> $past(CMD_VEL) == 32'h0;
  endproperty
  a_rev: assert property (p_rev)
    else $error("direction changed while moving");
  property p_err;
    TBL_ERR |-> CMD_VEL == 32'h0;
  endproperty
  a_err: assert property (p_err)
    else $error("motion during table error");
  property p_tick;
    $changed(CMD_POS) |=> $stable(CMD_POS) [*7];
  endproperty
  a_tick: assert property (p_tick)
    else $error("position moved between ticks");
  property p_mcode;
    $changed(MCODE) |-> $changed(CMD_POS);
  endproperty
  a_mcode: assert property (p_mcode)
    else $error("completion code changed without arrival");
endmodule

// ==== verification/pts_motor.sv ====
// servo motor stand-in: tracks peak speed and unsafe reversals
`timescale 1ns/100ps
module pts_motor (
  input wire logic clk, // system clock
  input wire logic rst, // reset, active high
  input wire logic [31:0] vel, // commanded speed
  input wire logic dir, // commanded direction
  output logic [31:0] peak, // highest speed seen
  output logic rev_bad // reversed while moving
);
  logic dir_r;
  logic [31:0] vel_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      peak <= 32'h0;
      rev_bad <= 1'b0;
      dir_r <= 1'b0;
      vel_r <= 32'h0;
    end else begin
      if (vel > peak)
        peak <= vel;
      if (dir != dir_r && vel_r != 32'h0)
        rev_bad <= 1'b1;
      dir_r <= dir;
      vel_r <= vel;
    end
  end
endmodule

// ==== verification/pts_seq_bench.sv ====
// self-checking bench for the point-table sequencer
`timescale 1ns/100ps
`include "pts_map.svh"
module pts_seq_bench;
  import pts_pkg::*;
  logic CLK = 1'b0, RST = 1'b1, S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0;
  logic S_AXI_BREADY = 1'b0, S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
  pts_addr_t S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
  pts_word_t S_AXI_WDATA = 32'h0, S_AXI_RDATA, CMD_POS, CMD_VEL, rdat, rpos;
  logic [3:0] S_AXI_WSTRB = 4'hF;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
  logic S_AXI_RVALID, CMD_DIR, TBL_ERR, rev_bad;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, brsp, rrsp;
  logic [7:0] MCODE, rmc;
  logic [31:0] peak;
  int n_errors = 0;
  int tests_run = 0;
  pts_seq #(.TICK_CYC(8)) DUT (
    .CLK, .RST, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY,
    .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY,
    .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR,
    .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP,
    .S_AXI_RVALID, .S_AXI_RREADY, .CMD_POS, .CMD_VEL, .CMD_DIR,
    .MCODE, .TBL_ERR
  );
  pts_motor MOT (.clk(CLK), .rst(RST), .vel(CMD_VEL), .dir(CMD_DIR),
    .peak(peak), .rev_bad(rev_bad));
  always #5 CLK = ~CLK;
  task automatic results;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    fork
      begin
        do @(posedge CLK); while (!S_AXI_AWREADY);
        S_AXI_AWVALID <= 1'b0;
      end
      begin
        do @(posedge CLK); while (!S_AXI_WREADY);
        S_AXI_WVALID <= 1'b0;
      end
    join
    repeat (2) @(posedge CLK);
    S_AXI_BREADY <= 1'b1;
    do @(posedge CLK); while (!S_AXI_BVALID);
    brsp = S_AXI_BRESP;
    S_AXI_BREADY <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge CLK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    do @(posedge CLK); while (!S_AXI_ARREADY);
    S_AXI_ARVALID <= 1'b0;
    @(posedge CLK);
    S_AXI_RREADY <= 1'b1;
    do @(posedge CLK); while (!S_AXI_RVALID);
    rdat = S_AXI_RDATA;
    rrsp = S_AXI_RRESP;
    S_AXI_RREADY <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rdat, e);
  endtask
  task automatic ent(input logic [7:0] i, input logic [31:0] p, s, dc,
    input logic [15:0] dw, input logic [3:0] ax, input logic [7:0] mc);
    wr(`PTS_A_TIDX, {24'h0, i});
    wr(`PTS_A_TPOS, p);
    wr(`PTS_A_TSPD, s);
    wr(`PTS_A_TDEC, dc);
    wr(`PTS_A_TDWELL, {16'h0, dw});
    wr(`PTS_A_TAUX, {16'h0, mc, 4'h0, ax});
    wr(`PTS_A_COMMIT, 32'h1);
  endtask
  task automatic go(input logic [7:0] e);
    wr(`PTS_A_TARGET, {24'h0, e});
    wr(`PTS_A_CTRL, 32'h0);
    wr(`PTS_A_CTRL, 32'h10);
  endtask
  task automatic run(input logic [7:0] e);
    go(e);
    do rd(`PTS_A_STATUS); while (rdat[2]);
  endtask
  task automatic fin(input logic [7:0] e, input logic [31:0] p,
    input logic [7:0] mc);
    rchk(`PTS_A_ACT, {24'h0, e});
    rchk(`PTS_A_MCODE, {24'h0, mc});
    chk(CMD_POS, p);
    chk(CMD_VEL, 32'h0);
  endtask
  task automatic wt(input logic [31:0] p);
    int n;
    n = 0;
    while (CMD_POS !== p && n < 4000) begin
      @(posedge CLK);
      n++;
    end
    chk(CMD_POS, p);
  endtask
  function automatic logic [31:0] dclamp(input int p);
    return (p > `PTS_DEG_MAX) ? `PTS_DEG_MAX : p;
  endfunction
  initial begin
    #500000;
    n_errors++;
    results();
  end
  initial begin
    void'($urandom(83));
    rpos = 32'h64 + $urandom % 300;
    rmc = 8'($urandom);
    repeat (5) @(posedge CLK);
    RST <= 1'b0;
    rchk(`PTS_A_GTC, `PTS_GTC_RST);
    rchk(`PTS_A_MAXSPD, `PTS_MAXSPD_RST);
    rchk(`PTS_A_PERMSPD, `PTS_PERMSPD_RST);
    rchk(`PTS_A_TARGET, 32'h1);
    rchk(`PTS_A_STATUS, 32'h0);
    rd(8'h48);
    chk({30'h0, rrsp}, {30'h0, `PTS_RESP_ERR});
    wr(8'h06, 32'h1);
    chk({30'h0, brsp}, {30'h0, `PTS_RESP_ERR});
    wr(`PTS_A_ACT, 32'h5);
    rchk(`PTS_A_ACT, 32'h0);
    ent(8'h01, 32'h0, 32'h14, 32'h0, 16'h0, 4'h0, 8'h01);
    ent(8'h02, rpos, 32'h14, 32'h5, 16'h0, 4'h0, rmc);
    ent(8'h03, 32'h4E20, 32'h1388, 32'h0, 16'h0, 4'h1, 8'h03);
    ent(8'h04, 32'h32, 32'h19, 32'h3, 16'h2, 4'h3, 8'h04);
    ent(8'h05, 32'h28, 32'hA, 32'h0, 16'h5, 4'h2, 8'h05);
    ent(8'h06, 32'h4F4C, 32'h1E, 32'h0, 16'h0, 4'h1, 8'h06);
    ent(8'h07, 32'hC8, 32'h12C, 32'h0, 16'h0, 4'h0, 8'h07);
    ent(8'h08, 32'h64, 32'h1E, 32'h0, 16'h1, 4'hA, 8'h08);
    ent(8'h09, 32'h32, 32'h1E, 32'h0, 16'h0, 4'hB, 8'h09);
    ent(8'h0A, 32'h0, 32'h1E, 32'h0, 16'h0, 4'h5, 8'h0A);
    ent(8'hFF, 32'h0, 32'h1E, 32'h0, 16'h0, 4'h1, 8'hFF);
    ent(8'h0B, 32'h1E, 32'h1E, 32'h0, 16'h0, 4'h9, 8'h0B);
    ent(8'h0C, 32'h12C, 32'h1E, 32'h0, 16'h1, 4'h8, 8'h0C);
    ent(8'h0D, 32'h7A120, 32'h1388, 32'h0, 16'h0, 4'h0, 8'h0D);
    run(8'h02);
    fin(8'h02, rpos, rmc);
    run(8'h03);
    fin(8'h05, 32'h4E7A, 8'h05);
    chk(peak, `PTS_MAXSPD_RST);
    run(8'h06);
    fin(8'h07, 32'hC8, 8'h07);
    chk({31'h0, rev_bad}, 32'h0);
    run(8'h08);
    fin(8'h01, 32'h0, 8'h01);
    run(8'h09);
    fin(8'h01, 32'h0, 8'h01);
    run(8'h0A);
    rchk(`PTS_A_STATUS, 32'h2);
    run(8'hFF);
    chk({31'h0, TBL_ERR}, 32'h1);
    wr(`PTS_A_CFG, 32'h1);
    run(8'h0D);
    fin(8'h0D, dclamp(500000), 8'h0D);
    wr(`PTS_A_CFG, 32'h0);
    go(8'h0B);
    wt(dclamp(500000) + 32'h3C);
    RST <= 1'b1;
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    chk(CMD_POS, 32'h0);
    go(8'h0C);
    chk({24'h0, MCODE}, 32'h0);
    wt(32'h12C);
    chk({24'h0, MCODE}, 32'h0C);
    rd(`PTS_A_STATUS);
    chk({31'h0, rdat[2]}, 32'h1);
    results();
  end
endmodule
bind pts_seq pts_seq_monitor MON (
  .CLK, .RST, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY,
  .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY,
  .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR,
  .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP,
  .S_AXI_RVALID, .S_AXI_RREADY, .CMD_POS, .CMD_VEL, .CMD_DIR,
  .MCODE, .TBL_ERR
);
